// File: mcd_decoder.sv
// Command frame decoder and reply generator for one axis
// Contract
// - Code 4 sends the axis to the target using programmed ramp and speed.
// - Move replies right after setup; new commands accepted while moving.
// - Move type 0 absolute, 1 offset, 2 stored coordinate index.
// - Move value is a full-range signed 32-bit number.
// - Over-long distance wraps; motion follows the shorter 32-bit difference.
// - A move writes the resolved target into axis parameter 0.
// - Soft stop or either spin command abandons a positioning move.
// - Code 5 writes value into selected axis parameter, volatile only.
// - Code 6 in direct mode replies the parameter, accumulator untouched.
// - Code 6 in standalone mode also loads the accumulator.
// - Success replies status 100; value carries data only for reads.
// - Persist copies the selected axis parameter into EEPROM.
// - Code 7 is persist, selecting parameter by the type byte alone; bank byte unused.
`timescale 1ns/10ps
module mcd_decoder (
    input wire logic clock_i,
    input wire logic reset_i,
    input wire logic [7:0] module_addr_i,
    input wire logic standalone_i,
    input wire logic rx_valid_i,
    input wire logic [7:0] rx_data_i,
    input wire logic [31:0] actual_pos_i,
    input wire logic tx_ready_i,
    input wire logic eeprom_ready_i,
    output logic tx_valid_o,
    output logic [7:0] tx_data_o,
    output logic move_start_o,
    output logic [31:0] move_target_o,
    output logic [31:0] move_delta_o,
    output logic stop_o,
    output logic spin_o,
    output logic spin_dir_o,
    output logic positioning_o,
    output logic eeprom_wr_o,
    output logic [7:0] eeprom_addr_o,
    output logic [31:0] eeprom_data_o,
    output logic [31:0] accum_o
);
    import mcd_pkg::*;

    typedef enum logic [4:0] {
        ST_RECV = 5'b00001,
        ST_EXEC = 5'b00010,
        ST_FETCH = 5'b00100,
        ST_DONE = 5'b01000,
        ST_SEND = 5'b10000
    } mcd_state_t;

    mcd_state_t state_q, state_d;
    logic [3:0] idx_q, idx_d;
    logic [7:0] addr_q, addr_d, instr_q, instr_d, type_q, type_d;
    logic [7:0] bank_q, bank_d, sum_q, sum_d, status_q, status_d;
    logic [31:0] value_q, value_d, reply_q, reply_d;
    logic rx_valid_s1_q, rx_valid_s2_q;
    logic [7:0] rx_data_s1_q, rx_data_s2_q;
    logic tx_valid_q, tx_valid_d;
    logic [7:0] tx_data_q, tx_data_d;
    logic move_start_q, move_start_d, stop_q, stop_d;
    logic spin_q, spin_d, spin_dir_q, spin_dir_d;
    logic pos_q, pos_d;
    logic [31:0] target_q, target_d, delta_q, delta_d, acc_q, acc_d;
    logic ee_wr_q, ee_wr_d;
    logic [7:0] ee_addr_q, ee_addr_d;
    logic [31:0] ee_data_q, ee_data_d;
    logic mem_wr;
    logic [6:0] mem_wr_addr, mem_rd_addr;
    logic [31:0] mem_wr_data, mem_rd_data;
    logic [31:0] resolved;

    // Link inputs arrive from another domain
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            rx_valid_s1_q <= 1'b0;
            rx_valid_s2_q <= 1'b0;
            rx_data_s1_q <= 8'h00;
            rx_data_s2_q <= 8'h00;
        end else begin
            rx_valid_s1_q <= rx_valid_i;
            rx_valid_s2_q <= rx_valid_s1_q;
            rx_data_s1_q <= rx_data_i;
            rx_data_s2_q <= rx_data_s1_q;
        end
    end

    mcd_mem u_mem (
        .clock_i(clock_i),
        .wr_en_i(mem_wr),
        .wr_addr_i(mem_wr_addr),
        .wr_data_i(mem_wr_data),
        .rd_addr_i(mem_rd_addr),
        .rd_data_o(mem_rd_data)
    );

    // Memory map: 0..63 axis parameters, 64.. coordinates
    always_comb begin
        mem_rd_addr = {1'b0, type_q[5:0]};
        if (instr_q == CMD_MOVE_TO_POSITION) begin
            mem_rd_addr = {1'b1, value_q[5:0]};
        end
    end

    always_comb begin
        resolved = value_q;
        unique case (type_q)
            OFFSET_TARGET_TYPE: resolved = actual_pos_i + value_q;
            STORED_POINT_TYPE: resolved = mem_rd_data;
            default: resolved = value_q;
        endcase
    end

    always_comb begin
        state_d = state_q;
        idx_d = idx_q;
        addr_d = addr_q;
        instr_d = instr_q;
        type_d = type_q;
        bank_d = bank_q;
        value_d = value_q;
        sum_d = sum_q;
        status_d = status_q;
        reply_d = reply_q;
        tx_valid_d = tx_valid_q;
        tx_data_d = tx_data_q;
        move_start_d = 1'b0;
        stop_d = 1'b0;
        spin_d = spin_q;
        spin_dir_d = spin_dir_q;
        pos_d = pos_q;
        target_d = target_q;
        delta_d = delta_q;
        acc_d = acc_q;
        ee_wr_d = ee_wr_q;
        ee_addr_d = ee_addr_q;
        ee_data_d = ee_data_q;
        mem_wr = 1'b0;
        mem_wr_addr = {1'b0, type_q[5:0]};
        mem_wr_data = value_q;
        unique case (state_q)
            ST_RECV: begin
                if (rx_valid_s2_q) begin
                    idx_d = idx_q + 4'h1;
                    sum_d = sum_q + rx_data_s2_q;
                    unique case (idx_q)
                        4'h0: addr_d = rx_data_s2_q;
                        4'h1: instr_d = rx_data_s2_q;
                        4'h2: type_d = rx_data_s2_q;
                        4'h3: bank_d = rx_data_s2_q;
                        4'h4, 4'h5, 4'h6, 4'h7:
                            value_d = {value_q[23:0], rx_data_s2_q};
                        default: begin
                            idx_d = 4'h0;
                            sum_d = 8'h00;
                            reply_d = 32'h0000_0000;
                            if (addr_q != module_addr_i) begin
                                state_d = ST_RECV;
                            end else if (sum_q != rx_data_s2_q) begin
                                status_d = STATUS_BAD_CHECKSUM;
                                state_d = ST_DONE;
                            end else begin
                                state_d = ST_FETCH;
                            end
                        end
                    endcase
                end
            end
            ST_FETCH: state_d = ST_EXEC;
            ST_EXEC: begin
                status_d = STATUS_OK;
                state_d = ST_DONE;
                unique case (instr_q)
                    CMD_SPIN_RIGHT, CMD_SPIN_LEFT: begin
                        pos_d = 1'b0;
                        spin_d = 1'b1;
                        spin_dir_d = (instr_q == CMD_SPIN_RIGHT);
                    end
                    CMD_SOFT_STOP: begin
                        pos_d = 1'b0;
                        spin_d = 1'b0;
                        stop_d = 1'b1;
                    end
                    CMD_MOVE_TO_POSITION: begin
                        if (type_q > STORED_POINT_TYPE ||
                            (type_q == STORED_POINT_TYPE &&
                             value_q >= {24'h0, STORED_POINT_TYPE_COUNT})) begin
                            status_d = STATUS_BAD_TYPE;
                        end else begin
                            target_d = resolved;
                            delta_d = resolved - actual_pos_i;
                            move_start_d = 1'b1;
                            pos_d = 1'b1;
                            spin_d = 1'b0;
                            mem_wr = 1'b1;
                            mem_wr_addr = {1'b0, PARAM_TARGET_POS[5:0]};
                            mem_wr_data = resolved;
                        end
                    end
                    CMD_AXIS_PARAM_WRITE: begin
                        if (type_q >= PARAM_COUNT) begin
                            status_d = STATUS_BAD_TYPE;
                        end else begin
                            mem_wr = 1'b1;
                        end
                    end
                    CMD_AXIS_PARAM_READ: begin
                        if (type_q >= PARAM_COUNT) begin
                            status_d = STATUS_BAD_TYPE;
                        end else begin
                            reply_d = (type_q == PARAM_ACTUAL_POS) ?
                                actual_pos_i : mem_rd_data;
                            if (standalone_i) begin
                                acc_d = reply_d;
                            end
                        end
                    end
                    CMD_AXIS_PARAM_PERSIST: begin
                        if (type_q >= PARAM_COUNT) begin
                            status_d = STATUS_BAD_TYPE;
                        end else if (!eeprom_ready_i) begin
                            state_d = ST_EXEC;
                        end else begin
                            ee_wr_d = 1'b1;
                            ee_addr_d = type_q;
                            ee_data_d = mem_rd_data;
                        end
                    end
                    default: status_d = STATUS_BAD_CMD;
                endcase
            end
            ST_DONE: begin
                ee_wr_d = 1'b0;
                tx_valid_d = 1'b1;
                tx_data_d = REPLY_ADDR;
                sum_d = REPLY_ADDR;
                idx_d = 4'h0;
                state_d = ST_SEND;
            end
            ST_SEND: begin
                if (tx_ready_i) begin
                    idx_d = idx_q + 4'h1;
                    unique case (idx_q)
                        4'h0: tx_data_d = module_addr_i;
                        4'h1: tx_data_d = status_q;
                        4'h2: tx_data_d = instr_q;
                        4'h3: tx_data_d = reply_q[31:24];
                        4'h4: tx_data_d = reply_q[23:16];
                        4'h5: tx_data_d = reply_q[15:8];
                        4'h6: tx_data_d = reply_q[7:0];
                        4'h7: tx_data_d = sum_q;
                        default: tx_data_d = 8'h00;
                    endcase
                    sum_d = sum_q + tx_data_d;
                    if (idx_q == REPLY_LAST) begin
                        tx_valid_d = 1'b0;
                        idx_d = 4'h0;
                        sum_d = 8'h00;
                        state_d = ST_RECV;
                    end
                end
            end
            default: state_d = ST_RECV;
        endcase
        if (move_start_q == 1'b0 && pos_q && actual_pos_i == target_q) begin
            pos_d = (state_q == ST_EXEC) ? pos_d : 1'b0;
        end
    end

    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            state_q <= ST_RECV;
            idx_q <= 4'h0;
            addr_q <= 8'h00;
            instr_q <= 8'h00;
            type_q <= 8'h00;
            bank_q <= 8'h00;
            value_q <= 32'h0000_0000;
            sum_q <= 8'h00;
            status_q <= 8'h00;
            reply_q <= 32'h0000_0000;
            tx_valid_q <= 1'b0;
            tx_data_q <= 8'h00;
            move_start_q <= 1'b0;
            stop_q <= 1'b0;
            spin_q <= 1'b0;
            spin_dir_q <= 1'b0;
            pos_q <= 1'b0;
            target_q <= 32'h0000_0000;
            delta_q <= 32'h0000_0000;
            acc_q <= ACC_RESET;
            ee_wr_q <= 1'b0;
            ee_addr_q <= 8'h00;
            ee_data_q <= 32'h0000_0000;
        end else begin
            state_q <= state_d;
            idx_q <= idx_d;
            addr_q <= addr_d;
            instr_q <= instr_d;
            type_q <= type_d;
            bank_q <= bank_d;
            value_q <= value_d;
            sum_q <= sum_d;
            status_q <= status_d;
            reply_q <= reply_d;
            tx_valid_q <= tx_valid_d;
            tx_data_q <= tx_data_d;
            move_start_q <= move_start_d;
            stop_q <= stop_d;
            spin_q <= spin_d;
            spin_dir_q <= spin_dir_d;
            pos_q <= pos_d;
            target_q <= target_d;
            delta_q <= delta_d;
            acc_q <= acc_d;
            ee_wr_q <= ee_wr_d;
            ee_addr_q <= ee_addr_d;
            ee_data_q <= ee_data_d;
        end
    end

    assign tx_valid_o = tx_valid_q;
    assign tx_data_o = tx_data_q;
    assign move_start_o = move_start_q;
    assign move_target_o = target_q;
    assign move_delta_o = delta_q;
    assign stop_o = stop_q;
    assign spin_o = spin_q;
    assign spin_dir_o = spin_dir_q;
    assign positioning_o = pos_q;
    assign eeprom_wr_o = ee_wr_q;
    assign eeprom_addr_o = ee_addr_q;
    assign eeprom_data_o = ee_data_q;
    assign accum_o = acc_q;
endmodule

// File: mcd_decoder_chk.sv
// Port assertions for the motion command decoder
`timescale 1ns/10ps
module mcd_decoder_chk
    import mcd_pkg::*;
(
    input wire logic clock_i,
    input wire logic reset_i,
    input wire logic standalone_i,
    input wire logic [31:0] actual_pos_i,
    input wire logic tx_ready_i,
    input wire logic eeprom_ready_i,
    input wire logic tx_valid_o,
    input wire logic [7:0] tx_data_o,
    input wire logic move_start_o,
    input wire logic [31:0] move_target_o,
    input wire logic [31:0] move_delta_o,
    input wire logic stop_o,
    input wire logic positioning_o,
    input wire logic eeprom_wr_o,
    input wire logic [31:0] accum_o
);
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (reset_i);
    chk_delta_wrap: assert property (
        move_start_o |-> move_delta_o == move_target_o - actual_pos_i)
        else $error("move delta wrong");
    chk_move_runs: assert property (
        move_start_o && move_target_o != actual_pos_i
        |-> ##[0:1] positioning_o) else $error("move not running");
    chk_stop_clears: assert property (stop_o |=> !positioning_o)
        else $error("stop kept move");
    chk_reply_soon: assert property (
        move_start_o |-> ##[1:3] $rose(tx_valid_o))
        else $error("move reply late");
    chk_reply_head: assert property (
        $rose(tx_valid_o) |-> tx_data_o == REPLY_ADDR)
        else $error("reply head wrong");
    chk_tx_hold: assert property (
        tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_data_o))
        else $error("reply byte moved");
    chk_accum_direct: assert property (
        !standalone_i ##1 !standalone_i |-> $stable(accum_o))
        else $error("accumulator moved");
    chk_ee_ready: assert property (eeprom_wr_o |-> eeprom_ready_i)
        else $error("store while busy");
    cover property (move_start_o ##[1:3] $rose(tx_valid_o));
    cover property (stop_o);
    cover property (eeprom_wr_o);
endmodule
bind mcd_decoder mcd_decoder_chk i_chk (
    .clock_i, .reset_i, .standalone_i, .actual_pos_i, .tx_ready_i,
    .eeprom_ready_i, .tx_valid_o, .tx_data_o, .move_start_o,
    .move_target_o, .move_delta_o, .stop_o, .positioning_o,
    .eeprom_wr_o, .accum_o
);

// File: mcd_decoder_tb.sv
// Self-checking testbench for the motion command decoder
`timescale 1ns/10ps
module mcd_decoder_tb;
    import mcd_pkg::*;
    localparam logic [7:0] ADDR = 8'h01;
    logic clock_i, reset_i, standalone_i, tx_ready_i, eeprom_ready_i;
    logic rx_valid_i, tx_valid_o, move_start_o, stop_o, spin_o;
    logic spin_dir_o, positioning_o, eeprom_wr_o, slow, ee_seen, bad;
    logic [7:0] rx_data_i, tx_data_o, eeprom_addr_o;
    logic [31:0] actual_pos_i, move_target_o, move_delta_o;
    logic [31:0] eeprom_data_o, accum_o;
    int num_errors, tests_run;
    int stops;
    logic [7:0] want_st;
    mcd_decoder i_dut (.clock_i, .reset_i, .module_addr_i(ADDR),
        .standalone_i, .rx_valid_i, .rx_data_i, .actual_pos_i,
        .tx_ready_i, .eeprom_ready_i, .tx_valid_o, .tx_data_o,
        .move_start_o, .move_target_o, .move_delta_o, .stop_o, .spin_o,
        .spin_dir_o, .positioning_o, .eeprom_wr_o, .eeprom_addr_o,
        .eeprom_data_o, .accum_o);
    mcd_host i_host (.clock_i, .slow_i(slow), .tx_valid_i(tx_valid_o),
        .tx_data_i(tx_data_o), .rx_valid_o(rx_valid_i),
        .rx_data_o(rx_data_i), .tx_ready_o(tx_ready_i));
    initial begin
        clock_i = 1'b0;
        forever #5 clock_i = ~clock_i;
    end
    always @(posedge clock_i)
        if (eeprom_wr_o === 1'b1) ee_seen <= 1'b1;
    always @(posedge clock_i)
        if (stop_o === 1'b1) stops++;
    task automatic end_sim();
        $display("errors %0d checks %0d", num_errors, tests_run);
        if (num_errors == 0 && tests_run > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic cmp(input logic [31:0] g, e);
        tests_run++;
        if (g !== e) begin
            num_errors++;
            $display("CHECK FAILED %0t got %h want %h", $time, g, e);
        end
    endtask
    // Send one frame, wait for the reply, compare its first four bytes, and all nine for reads with a good checksum
    task automatic cmd(input logic [7:0] ins, typ,
            input logic [31:0] val, ex);
        logic [7:0] e [0:8];
        logic rd;
        int n;
        rd = ins == CMD_AXIS_PARAM_READ && !bad;
        e = '{REPLY_ADDR, ADDR, bad ? STATUS_BAD_CHECKSUM : want_st,
            ins, ex[31:24], ex[23:16], ex[15:8], ex[7:0], 8'h00};
        for (int i = 0; i < 8; i++) e[8] += e[i];
        i_host.send(ADDR, ins, typ, val, {7'h0, bad});
        n = 0;
        while (i_host.rcnt !== 4'h9 && n < 400) begin
            @(negedge clock_i);
            n++;
        end
        @(negedge clock_i);
        cmp(32'(i_host.rcnt), 32'h9);
        for (int i = 0; i < 9; i++)
            if (i < 4 || rd) cmp(32'(i_host.rep[i]), 32'(e[i]));
    endtask
    task automatic mv(input logic [7:0] typ, input logic [31:0] val);
        cmd(CMD_MOVE_TO_POSITION, typ, val, 32'h0);
    endtask
    task automatic t_move();
        actual_pos_i = 32'h0;
        mv(FIXED_TARGET_TYPE, 32'd90000);
        cmp(move_target_o, 32'd90000);
        cmp(32'(positioning_o), 32'h1);
        cmd(CMD_AXIS_PARAM_READ, PARAM_TARGET_POS, 32'h0, 32'd90000);
        actual_pos_i = 32'd1000;
        mv(OFFSET_TARGET_TYPE, 32'hffff_d8f0);
        cmp(move_target_o, 32'hffff_dcd8);
        cmp(move_delta_o, 32'hffff_d8f0);
        actual_pos_i = 32'h7fff_fff0;
        mv(FIXED_TARGET_TYPE, 32'h8000_0000);
        cmp(move_delta_o, 32'h0000_0010);
        actual_pos_i = 32'h8000_0000;
        repeat (2) @(negedge clock_i);
        cmp(32'(positioning_o), 32'h0);
    endtask
    task automatic t_stop();
        logic [7:0] ops [0:2];
        ops = '{CMD_SOFT_STOP, CMD_SPIN_LEFT, CMD_SPIN_RIGHT};
        actual_pos_i = 32'h0;
        for (int i = 0; i < 3; i++) begin
            mv(FIXED_TARGET_TYPE, 32'd5000);
            cmp(32'(positioning_o), 32'h1);
            cmd(ops[i], 8'h00, 32'd1000, 32'h0);
            cmp(32'(positioning_o), 32'h0);
            cmp(32'(spin_o), 32'(i > 0));
            if (i > 0) cmp(32'(spin_dir_o), 32'(i == 2));
        end
        cmp(32'(spin_dir_o), 32'h1);
        cmp(32'(stops), 32'h1);
    endtask
    // Refused types, ranges and codes leave the axis alone
    task automatic t_refuse();
        want_st = STATUS_BAD_TYPE;
        mv(STORED_POINT_TYPE, {24'h0, STORED_POINT_TYPE_COUNT});
        mv(8'h03, 32'd100);
        cmd(CMD_AXIS_PARAM_WRITE, PARAM_COUNT, 32'd7, 32'h0);
        cmd(CMD_AXIS_PARAM_READ, PARAM_COUNT, 32'h0, 32'h0);
        cmp(move_target_o, 32'd5000);
        want_st = STATUS_BAD_CMD;
        cmd(8'h0f, 8'h00, 32'h0, 32'h0);
        want_st = STATUS_OK;
    endtask
    task automatic t_param();
        cmd(CMD_AXIS_PARAM_WRITE, 8'h04, 32'd1000, 32'h0);
        cmd(CMD_AXIS_PARAM_READ, 8'h04, 32'h0, 32'd1000);
        cmp(accum_o, ACC_RESET);
        standalone_i = 1'b1;
        cmd(CMD_AXIS_PARAM_READ, 8'h04, 32'h0, 32'd1000);
        cmp(accum_o, 32'd1000);
        standalone_i = 1'b0;
    endtask
    task automatic t_persist();
        cmd(CMD_AXIS_PARAM_WRITE, 8'h06, 32'h1234_5678, 32'h0);
        slow = 1'b1;
        ee_seen = 1'b0;
        fork
            cmd(CMD_AXIS_PARAM_PERSIST, 8'h06, 32'h0, 32'h0);
            begin
                repeat (60) @(negedge clock_i);
                cmp(32'(ee_seen), 32'h0);
                eeprom_ready_i = 1'b1;
            end
        join
        cmp(32'(ee_seen), 32'h1);
        cmp(32'(eeprom_addr_o), 32'h6);
        cmp(eeprom_data_o, 32'h1234_5678);
        slow = 1'b0;
    endtask
    task automatic t_err();
        bad = 1'b1;
        cmd(CMD_AXIS_PARAM_READ, 8'h04, 32'h0, 32'h0);
        bad = 1'b0;
        i_host.send(8'h05, CMD_SOFT_STOP, 8'h00, 32'h0, 8'h00);
        repeat (20) @(negedge clock_i);
        cmp(32'(i_host.rcnt), 32'h0);
    endtask
    initial begin
        #100us;
        num_errors++;
        end_sim();
    end
    initial begin
        num_errors = 0;
        tests_run = 0;
        reset_i = 1'b1;
        standalone_i = 1'b0;
        eeprom_ready_i = 1'b0;
        actual_pos_i = 32'h0;
        slow = 1'b0;
        ee_seen = 1'b0;
        bad = 1'b0;
        stops = 0;
        want_st = STATUS_OK;
        repeat (8) @(negedge clock_i);
        reset_i = 1'b0;
        t_move();
        t_stop();
        t_param();
        t_persist();
        t_err();
        t_refuse();
        end_sim();
    end
endmodule

// File: mcd_host.sv
// Host model sending command frames and taking replies
`timescale 1ns/10ps
module mcd_host (
    input wire logic clock_i,
    input wire logic slow_i,
    input wire logic tx_valid_i,
    input wire logic [7:0] tx_data_i,
    output logic rx_valid_o,
    output logic [7:0] rx_data_o,
    output logic tx_ready_o
);
    logic [7:0] rep [0:8];
    logic [3:0] rcnt;
    initial begin
        rx_valid_o = 1'b0;
        rx_data_o = 8'h00;
        tx_ready_o = 1'b0;
        rcnt = 4'h0;
    end
    // Sink ready always, or every other cycle when slow
    always @(negedge clock_i)
        tx_ready_o <= !slow_i || !tx_ready_o;
    always @(posedge clock_i)
        if (tx_valid_i && tx_ready_o) begin
            rep[rcnt] <= tx_data_i;
            rcnt <= rcnt + 4'h1;
        end
    // Data line holds the byte a cycle either side of its strobe, then its inverse
    task automatic send(input logic [7:0] adr, ins, typ,
            input logic [31:0] val, input logic [7:0] err);
        logic [7:0] b [0:8];
        b = '{adr, ins, typ, 8'h00, val[31:24], val[23:16],
            val[15:8], val[7:0], err};
        for (int i = 0; i < 8; i++) b[8] += b[i];
        rcnt = 4'h0;
        for (int i = 0; i < 9; i++) begin
            @(negedge clock_i) rx_data_o = b[i];
            @(negedge clock_i) rx_valid_o = 1'b1;
            @(negedge clock_i) rx_valid_o = 1'b0;
            @(negedge clock_i) rx_data_o = ~b[i];
        end
    endtask
endmodule

// File: mcd_mem.sv
// Parameter and coordinate memory with registered read
`timescale 1ns/10ps
module mcd_mem (
    input wire logic clock_i,
    input wire logic wr_en_i,
    input wire logic [6:0] wr_addr_i,
    input wire logic [31:0] wr_data_i,
    input wire logic [6:0] rd_addr_i,
    output logic [31:0] rd_data_o
);
    logic [31:0] mem [0:127];
    always_ff @(posedge clock_i) begin
        if (wr_en_i) begin
            mem[wr_addr_i] <= wr_data_i;
        end
        rd_data_o <= mem[rd_addr_i];
    end
endmodule

// File: mcd_pkg.sv
// Shared constants for the motion command decoder
package mcd_pkg;
    localparam logic [7:0] CMD_SPIN_RIGHT = 8'h01;
    localparam logic [7:0] CMD_SPIN_LEFT = 8'h02;
    localparam logic [7:0] CMD_SOFT_STOP = 8'h03;
    localparam logic [7:0] CMD_MOVE_TO_POSITION = 8'h04;
    localparam logic [7:0] CMD_AXIS_PARAM_WRITE = 8'h05;
    localparam logic [7:0] CMD_AXIS_PARAM_READ = 8'h06;
    localparam logic [7:0] CMD_AXIS_PARAM_PERSIST = 8'h07;
    localparam logic [7:0] FIXED_TARGET_TYPE = 8'h00;
    localparam logic [7:0] OFFSET_TARGET_TYPE = 8'h01;
    localparam logic [7:0] STORED_POINT_TYPE = 8'h02;
    localparam logic [7:0] PARAM_TARGET_POS = 8'h00;
    localparam logic [7:0] PARAM_ACTUAL_POS = 8'h01;
    localparam logic [7:0] STATUS_OK = 8'h64;
    localparam logic [7:0] STATUS_BAD_CHECKSUM = 8'h01;
    localparam logic [7:0] STATUS_BAD_CMD = 8'h02;
    localparam logic [7:0] STATUS_BAD_TYPE = 8'h03;
    localparam logic [7:0] REPLY_ADDR = 8'h02;
    localparam logic [3:0] FRAME_LAST = 4'h8;
    localparam logic [3:0] REPLY_LAST = 4'h8;
    localparam logic [7:0] PARAM_COUNT = 8'h40;
    localparam logic [7:0] STORED_POINT_TYPE_COUNT = 8'h15;
    localparam logic [31:0] ACC_RESET = 32'h0000_0000;
endpackage
